// [tiex_pkg.sv]
// constants and types for the trap, illegal and trace exception unit
package tiex_pkg;
    // vector numbers
    localparam logic [7:0] TIEX_VEC_ILLEGAL = 8'h04;
    localparam logic [7:0] TIEX_VEC_ZERO_DIV = 8'h05;
    localparam logic [7:0] TIEX_VEC_BOUNDS = 8'h06;
    localparam logic [7:0] TIEX_VEC_OVERFLOW = 8'h07;
    localparam logic [7:0] TIEX_VEC_PRIVILEGE = 8'h08;
    localparam logic [7:0] TIEX_VEC_TRACE = 8'h09;
    localparam logic [7:0] TIEX_VEC_LINE_A = 8'h0a;
    localparam logic [7:0] TIEX_VEC_LINE_F = 8'h0b;
    localparam logic [7:0] TIEX_VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] TIEX_VEC_TRAP_BASE = 8'h20;
    // opcode patterns
    localparam logic [15:0] TIEX_OP_ILL_A = 16'h4afa;
    localparam logic [15:0] TIEX_OP_ILL_B = 16'h4afb;
    localparam logic [15:0] TIEX_OP_ILL_C = 16'h4afc;
    localparam logic [12:0] TIEX_OP_BREAK_HI = 13'h0909;
    localparam logic [3:0] TIEX_OP_LINE_A = 4'ha;
    localparam logic [3:0] TIEX_OP_LINE_F = 4'hf;
    localparam logic [11:0] TIEX_OP_TRAP_HI = 12'h4e4;
    // status word bit positions
    localparam int TIEX_SR_TRACE = 15;
    localparam int TIEX_SR_SUPER = 13;
    // format/offset word, break cycle function code, status word at reset
    localparam logic [3:0] TIEX_FMT_SHORT = 4'h0;
    localparam int TIEX_OFS_SHIFT = 2;
    localparam logic [2:0] TIEX_FC_BREAK = 3'h7;
    localparam logic [15:0] TIEX_SR_RESET = 16'h2700;
    typedef enum logic [2:0] {
        TIEX_IDLE, TIEX_BRK_CYC, TIEX_STACK, TIEX_VFETCH, TIEX_TRACE_PEND, TIEX_IRQ_PEND
    } tiex_state_t;
    typedef struct packed {
        tiex_state_t st;
        logic [15:0] sr;
        logic [15:0] sr_copy;
        logic [31:0] ret_pc;
        logic [7:0] vec;
        logic [15:0] fmt_ofs;
        logic trace_due;
        logic irq_due;
        logic [7:0] irq_vec;
        logic brk_req;
    } tiex_regs_t;
endpackage

// [tiex_unit.sv]
// exception recognition and sequencing for traps, illegal opcodes and trace
`timescale 1ns/1ps
`default_nettype none
module tiex_unit
    import tiex_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic breakpoint_variant,
    input wire logic instr_done,
    input wire logic [15:0] opcode,
    input wire logic [31:0] instr_pc,
    input wire logic [31:0] next_pc,
    input wire logic legal_opcode,
    input wire logic priv_opcode,
    input wire logic overflow_trap_instr,
    input wire logic overflow_flag,
    input wire logic bounds_check_instr,
    input wire logic out_of_bounds,
    input wire logic signed_divide_instr,
    input wire logic unsigned_divide_instr,
    input wire logic divisor_zero,
    input wire logic instr_aborted,
    input wire logic irq_taken,
    input wire logic [7:0] irq_vector,
    input wire logic iack_done,
    input wire logic [15:0] sr_in,
    input wire logic sr_load,
    input wire logic transfer_acknowledge_in,
    input wire logic bus_error_in,
    input wire logic valid_peripheral_address_in,
    input wire logic stack_done,
    input wire logic vector_done,
    output logic brk_cycle_req,
    output logic [2:0] function_code_lines,
    output logic [31:0] brk_address,
    output logic stack_req,
    output logic [15:0] stacked_sr,
    output logic [31:0] stacked_pc,
    output logic [15:0] stacked_fmt_ofs,
    output logic vector_fetch_req,
    output logic [7:0] vector_number,
    output logic [15:0] status_word,
    output logic exc_busy
);
    // state copy and its next value, synchronised pins, decode results
    tiex_regs_t r_q, r_d;
    logic dta_m, dta_s, be_m, be_s, vpa_m, vpa_s;
    logic ill, brk, trap_op, priv_v, line_a, line_f, forced;
    logic [7:0] f_vec;
    logic [31:0] f_pc;

    // pin inputs pass two flip-flops
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dta_m <= 1'b0;
            dta_s <= 1'b0;
            be_m <= 1'b0;
            be_s <= 1'b0;
            vpa_m <= 1'b0;
            vpa_s <= 1'b0;
        end
        else
        begin
            dta_m <= transfer_acknowledge_in;
            dta_s <= dta_m;
            be_m <= bus_error_in;
            be_s <= be_m;
            vpa_m <= valid_peripheral_address_in;
            vpa_s <= vpa_m;
        end
    end

    // start a frame: copy status, supervisor on, trace off
    function automatic tiex_regs_t begin_exc(input tiex_regs_t cur, input logic [7:0] v,
                                             input logic [31:0] pc);
        tiex_regs_t n;
        n = cur;
        // step one: keep the old status, then supervisor on with tracing off
        n.sr_copy = cur.sr;
        n.sr[TIEX_SR_SUPER] = 1'b1;
        n.sr[TIEX_SR_TRACE] = 1'b0;
        // step two: vector number and the frame words to be stacked
        n.vec = v;
        n.ret_pc = pc;
        n.fmt_ofs = {TIEX_FMT_SHORT, 12'({4'h0, v} << TIEX_OFS_SHIFT)};
        // step three: stacking, then the vector fetch
        n.st = TIEX_STACK;
        return n;
    endfunction

    // the three reserved words that are illegal whatever the decoder says
    function automatic logic is_fixed_illegal(input logic [15:0] op);
        return op == TIEX_OP_ILL_A || op == TIEX_OP_ILL_B || op == TIEX_OP_ILL_C;
    endfunction

    // breakpoint words share their upper thirteen bits
    function automatic logic is_brk_opcode(input logic [15:0] op);
        return op[15:3] == TIEX_OP_BREAK_HI;
    endfunction

    // software trap: the low opcode field picks one of sixteen vectors
    function automatic logic [7:0] trap_vector(input logic [15:0] op);
        return TIEX_VEC_TRAP_BASE + {4'h0, op[3:0]};
    endfunction

    // opcode classification
    always_comb
    begin
        line_a = opcode[15:12] == TIEX_OP_LINE_A;
        line_f = opcode[15:12] == TIEX_OP_LINE_F;
        brk = breakpoint_variant && is_brk_opcode(opcode);
        ill = !line_a && !line_f && (!legal_opcode || brk || is_fixed_illegal(opcode));
        trap_op = opcode[15:4] == TIEX_OP_TRAP_HI && !ill;
        priv_v = priv_opcode && !r_q.sr[TIEX_SR_SUPER] && !ill && !line_a && !line_f;

        // forced exceptions in priority order, faults before traps
        f_pc = next_pc;
        f_vec = 8'h00;
        forced = 1'b1;
        if (line_a)
        begin
            f_vec = TIEX_VEC_LINE_A;
            f_pc = instr_pc;
        end
        else if (line_f)
        begin
            f_vec = TIEX_VEC_LINE_F;
            f_pc = instr_pc;
        end
        else if (ill)
        begin
            f_vec = TIEX_VEC_ILLEGAL;
            f_pc = instr_pc;
        end
        else if (priv_v)
        begin
            f_vec = TIEX_VEC_PRIVILEGE;
            f_pc = instr_pc;
        end
        else if (trap_op)
            f_vec = trap_vector(opcode);
        else if (overflow_trap_instr && overflow_flag)
            f_vec = TIEX_VEC_OVERFLOW;
        else if (bounds_check_instr && out_of_bounds)
            f_vec = TIEX_VEC_BOUNDS;
        else if ((signed_divide_instr || unsigned_divide_instr) && divisor_zero)
            f_vec = TIEX_VEC_ZERO_DIV;
        else
            forced = 1'b0;
    end

    // sequencer state
    always_comb
    begin
        // hold everything unless a branch below changes it
        r_d = r_q;
        // the status word may be reloaded only between exceptions
        if (sr_load && r_q.st == TIEX_IDLE)
            r_d.sr = sr_in;
        case (r_q.st)
            // between instructions: take a finished instruction or an interrupt
            TIEX_IDLE:
            begin
                if (instr_done && !instr_aborted)
                begin
                    // trace only if bit set at start and instruction executed
                    r_d.trace_due = r_q.sr[TIEX_SR_TRACE] && !ill && !priv_v
                                    && !line_a && !line_f;
                    r_d.irq_due = irq_taken;
                    r_d.irq_vec = irq_vector;
                    if (forced)
                    begin
                        r_d = begin_exc(r_d, f_vec, f_pc);
                        if (brk)
                        begin
                            r_d.st = TIEX_BRK_CYC;
                            r_d.brk_req = 1'b1;
                        end
                    end
                    else if (r_d.trace_due)
                    begin
                        r_d.trace_due = 1'b0;
                        r_d = begin_exc(r_d, TIEX_VEC_TRACE, next_pc);
                    end
                    else if (irq_taken)
                        r_d.st = TIEX_IRQ_PEND;
                end
                // interrupt between instructions: no trace is owed
                else if (irq_taken && !instr_done)
                begin
                    r_d.irq_vec = irq_vector;
                    r_d.st = TIEX_IRQ_PEND;
                end
            end
            // breakpoint acknowledge cycle runs until any termination pin
            TIEX_BRK_CYC:
            begin
                if (dta_s || be_s || vpa_s)
                begin
                    r_d.brk_req = 1'b0;
                    r_d.st = TIEX_STACK;
                end
            end
            // short frame being stacked
            TIEX_STACK:
                if (stack_done)
                    r_d.st = TIEX_VFETCH;
            // new program counter fetched from the vector
            TIEX_VFETCH:
            begin
                if (vector_done)
                begin
                    // pending lower-priority work resumes only now
                    if (r_q.trace_due)
                        r_d.st = TIEX_TRACE_PEND;
                    else if (r_q.irq_due)
                        r_d.st = TIEX_IRQ_PEND;
                    else
                        r_d.st = TIEX_IDLE;
                end
            end
            // trace owed after a forced exception
            TIEX_TRACE_PEND:
            begin
                r_d.trace_due = 1'b0;
                r_d = begin_exc(r_d, TIEX_VEC_TRACE, next_pc);
            end
            // waiting for the interrupt acknowledge cycle to end
            TIEX_IRQ_PEND:
            begin
                if (iack_done)
                begin
                    r_d.irq_due = 1'b0;
                    // bus error on acknowledge means spurious
                    r_d = begin_exc(r_d, be_s ? TIEX_VEC_SPURIOUS : r_q.irq_vec, next_pc);
                end
            end
            // unused encodings fall back to idle
            default:
                r_d.st = TIEX_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            // idle, reset status, nothing owed
            r_q <= '0;
            r_q.st <= TIEX_IDLE;
            r_q.sr <= TIEX_SR_RESET;
        end
        else
            r_q <= r_d;
    end

    // breakpoint acknowledge cycle: function code all high, address all low
    assign brk_cycle_req = r_q.brk_req;
    assign function_code_lines = r_q.brk_req ? TIEX_FC_BREAK : 3'h0;
    assign brk_address = 32'h0000_0000;

    // frame words stand while stacking
    assign stack_req = r_q.st == TIEX_STACK;
    assign stacked_sr = r_q.sr_copy;
    assign stacked_pc = r_q.ret_pc;
    assign stacked_fmt_ofs = r_q.fmt_ofs;

    // vector fetch request and its number
    assign vector_fetch_req = r_q.st == TIEX_VFETCH;
    assign vector_number = r_q.vec;

    // live status word and busy flag
    assign status_word = r_q.sr;
    assign exc_busy = r_q.st != TIEX_IDLE;
endmodule
`default_nettype wire

// [tiex_unit_asserts.sv]
// port assertions for the exception unit
`timescale 1ns/1ps
`default_nettype none
module tiex_unit_chk
    import tiex_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic instr_done,
    input wire logic [15:0] opcode,
    input wire logic instr_aborted,
    input wire logic exc_busy,
    input wire logic brk_cycle_req,
    input wire logic [2:0] function_code_lines,
    input wire logic stack_req,
    input wire logic [15:0] stacked_fmt_ofs,
    input wire logic vector_fetch_req,
    input wire logic vector_done,
    input wire logic [7:0] vector_number,
    input wire logic [15:0] status_word
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    property p_fc; brk_cycle_req |-> function_code_lines == TIEX_FC_BREAK && !stack_req; endproperty
    a_fc: assert property (p_fc) else $error("bad break cycle");
    property p_ofs; stack_req |-> stacked_fmt_ofs == {6'h0, vector_number, 2'h0}; endproperty
    a_ofs: assert property (p_ofs) else $error("bad offset");
    property p_sup; stack_req |-> status_word[TIEX_SR_SUPER] && !status_word[TIEX_SR_TRACE]; endproperty
    a_sup: assert property (p_sup) else $error("bad status");
    property p_one; vector_fetch_req |-> !stack_req && !brk_cycle_req; endproperty
    a_one: assert property (p_one) else $error("overlap");
    property p_hold; vector_fetch_req && !vector_done |=> vector_fetch_req && $stable(vector_number); endproperty
    a_hold: assert property (p_hold) else $error("fetch dropped");
    property p_trap; instr_done && !exc_busy && !instr_aborted && opcode[15:4] == TIEX_OP_TRAP_HI
        |=> stack_req && vector_number == (TIEX_VEC_TRAP_BASE | {4'h0, $past(opcode[3:0])}); endproperty
    a_trap: assert property (p_trap) else $error("bad trap");
    property p_ill; instr_done && !exc_busy && !instr_aborted
        && (opcode == 16'h4afa || opcode == 16'h4afb || opcode == 16'h4afc)
        |=> stack_req && vector_number == TIEX_VEC_ILLEGAL; endproperty
    a_ill: assert property (p_ill) else $error("bad illegal");
    property p_abort; instr_done && !exc_busy && instr_aborted |=> (!stack_req) [*8]; endproperty
    a_abort: assert property (p_abort) else $error("aborted traced");
    c_brk: cover property (brk_cycle_req);
    c_trace: cover property (stack_req && vector_number == TIEX_VEC_TRACE);
    c_spur: cover property (stack_req && vector_number == TIEX_VEC_SPURIOUS);
endmodule
bind tiex_unit tiex_unit_chk chk_u (.*);
`default_nettype wire

// [tiex_bus_model.sv]
// bus unit and acknowledge responder model
`timescale 1ns/1ps
`default_nettype none
module tiex_bus_model (
    input wire logic clk_sys,
    input wire logic stack_req,
    input wire logic vector_fetch_req,
    input wire logic brk_cycle_req,
    input wire logic slow,
    input wire logic [1:0] term_sel,
    input wire logic nobody,
    output logic stack_done,
    output logic vector_done,
    output logic transfer_acknowledge_in,
    output logic bus_error_in,
    output logic valid_peripheral_address_in
);
    logic [2:0] cnt = 3'h0;
    logic term_on = 1'b0;
    logic hit;
    // answer a standing request after one or four cycles
    assign hit = cnt == (slow ? 3'h4 : 3'h1);
    always @(posedge clk_sys)
    begin
        cnt <= (stack_req | vector_fetch_req | brk_cycle_req) && !hit ? cnt + 3'h1 : 3'h0;
        term_on <= brk_cycle_req & (term_on | hit);
    end
    assign stack_done = stack_req & hit;
    assign vector_done = vector_fetch_req & hit;
    // chosen pin ends the break cycle; with no responder the acknowledge ends in bus error
    assign transfer_acknowledge_in = term_on & term_sel == 2'h0;
    assign bus_error_in = term_on & term_sel == 2'h1 | nobody;
    assign valid_peripheral_address_in = term_on & term_sel == 2'h2;
endmodule
`default_nettype wire

// [tiex_unit_bench.sv]
// self-checking bench for the exception unit
`timescale 1ns/1ps
`default_nettype none
module tiex_unit_bench;
    import tiex_pkg::*;
    logic clk_sys = 1'b0, srst = 1'b1, breakpoint_variant = 1'b0, instr_done = 1'b0, iack_done = 1'b0;
    logic sr_load = 1'b0, slow = 1'b0, nobody = 1'b0, legal_opcode, priv_opcode, irq_taken, instr_aborted;
    logic overflow_trap_instr, overflow_flag, bounds_check_instr, out_of_bounds, signed_divide_instr;
    logic unsigned_divide_instr, divisor_zero, transfer_acknowledge_in, bus_error_in, stack_done, vector_done;
    logic valid_peripheral_address_in, brk_cycle_req, stack_req, vector_fetch_req, exc_busy;
    logic [1:0] term_sel = 2'h0;
    logic [2:0] function_code_lines;
    logic [7:0] irq_vector = 8'h40, vector_number;
    logic [10:0] cond = 11'h0;
    logic [15:0] opcode = 16'h0, sr_in = 16'h0, stacked_sr, stacked_fmt_ofs, status_word;
    logic [15:0] sr_exp = TIEX_SR_RESET;
    logic [31:0] instr_pc = 32'h100, next_pc = 32'h104, brk_address, stacked_pc;
    int n_errors = 0, n_compared = 0;
    // one word feeds all instruction qualifiers
    assign {legal_opcode, priv_opcode, irq_taken, instr_aborted, overflow_trap_instr, overflow_flag,
        bounds_check_instr, out_of_bounds, signed_divide_instr, unsigned_divide_instr, divisor_zero} = cond;
    tiex_unit dut_u (.*);
    tiex_bus_model bus_u (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic setsr(input logic [15:0] v);
        sr_in = v;
        sr_exp = v;
        sr_load = 1'b1;
        tick();
        sr_load = 1'b0;
    endtask
    // wait for stacking (or its absence), judge it, let the vector fetch end
    task automatic exc(input logic [7:0] v, input logic [1:0] m);
        int n;
        logic brk_ok;
        brk_ok = 1'b0;
        for (n = 0; stack_req !== 1'b1 && n < 30; n++)
        begin
            // breakpoint cycle: function code all high, address all low
            if (brk_cycle_req === 1'b1)
                brk_ok = function_code_lines === 3'h7 && brk_address === 32'h0;
            tick();
        end
        check(brk_ok, breakpoint_variant && opcode >= 16'h4848 && opcode <= 16'h484f);
        check(stack_req, v != 8'h0);
        if (v != 8'h0)
        begin
            check(vector_number, v);
            check(exc_busy, 1'b1);
            check(stacked_sr, sr_exp);
            check(stacked_fmt_ofs, {6'h0, v, 2'h0});
            sr_exp[15] = 1'b0;
            sr_exp[13] = 1'b1;
            check(status_word, sr_exp);
            check({status_word[15], status_word[13]}, 2'h1);
            if (m != 2'h2)
                check(stacked_pc, m[0] ? next_pc : instr_pc);
            for (n = 0; (vector_fetch_req & vector_done) !== 1'b1 && n < 30; n++)
                tick();
            tick();
        end
    endtask
    task automatic run(input logic [15:0] op, input logic [10:0] c, input logic [7:0] v, input logic [1:0] m);
        instr_pc = instr_pc + 32'h10;
        next_pc = instr_pc + 32'h4;
        opcode = op;
        cond = c;
        instr_done = 1'b1;
        tick();
        instr_done = 1'b0;
        cond = 11'h0;
        exc(v, m);
    endtask
    task automatic iack(input logic [7:0] v);
        repeat (4)
            tick();
        iack_done = 1'b1;
        tick();
        iack_done = 1'b0;
        exc(v, 2'h2);
    endtask
    task automatic t_traps();
        slow = 1'b1;
        setsr(16'h0000);
        run(16'h4e4f, 11'h400, 8'h2f, 2'h1);
        run(16'h4e76, 11'h440, 8'h00, 2'h1);
        run(16'h4e76, 11'h460, TIEX_VEC_OVERFLOW, 2'h1);
        run(16'h4180, 11'h418, TIEX_VEC_BOUNDS, 2'h1);
        run(16'h81c0, 11'h405, TIEX_VEC_ZERO_DIV, 2'h1);
        run(16'h80c0, 11'h403, TIEX_VEC_ZERO_DIV, 2'h1);
        slow = 1'b0;
        setsr(16'h0000);
        run(16'h4e73, 11'h600, TIEX_VEC_PRIVILEGE, 2'h0);
        run(16'h4e72, 11'h600, 8'h00, 2'h0);
    endtask
    task automatic t_illegal();
        run(16'h4afb, 11'h000, TIEX_VEC_ILLEGAL, 2'h0);
        run(16'h4afc, 11'h400, TIEX_VEC_ILLEGAL, 2'h0);
        run(16'ha123, 11'h000, TIEX_VEC_LINE_A, 2'h0);
        run(16'hf456, 11'h000, TIEX_VEC_LINE_F, 2'h0);
        breakpoint_variant = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            term_sel = i[1:0];
            run(16'h484f - 16'(i * 3), 11'h000, TIEX_VEC_ILLEGAL, 2'h0);
        end
    endtask
    task automatic t_trace();
        setsr(16'h8000);
        run(16'h4e71, 11'h400, TIEX_VEC_TRACE, 2'h1);
        setsr(16'h8000);
        run(16'h4afc, 11'h000, TIEX_VEC_ILLEGAL, 2'h0);
        exc(8'h00, 2'h0);
        setsr(16'h8000);
        run(16'h4e40, 11'h480, 8'h00, 2'h1);
        setsr(16'h8000);
        run(16'h4e40, 11'h500, 8'h20, 2'h1);
        exc(TIEX_VEC_TRACE, 2'h1);
        iack(8'h40);
        nobody = 1'b1;
        cond = 11'h100;
        tick();
        cond = 11'h0;
        iack(TIEX_VEC_SPURIOUS);
        nobody = 1'b0;
    endtask
    initial
    begin
        repeat (5)
            tick();
        srst = 1'b0;
        tick();
        t_traps();
        t_illegal();
        t_trace();
        conclude();
    end
    // cut a hang short
    initial
    begin
        repeat (3000)
            @(posedge clk_sys);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
